// ===== rtl/reset_sequence_controller.sv
// Reset sequence controller: selects, times and ends the reset sequences and boot firmware.
`timescale 1ns/1ps
module reset_sequence_controller #(
    parameter int DESTR_SELFTEST_CYC_P = reset_seq_pkg::DESTR_SELFTEST_CYC,
    parameter int DESTR_PLAIN_CYC_P = reset_seq_pkg::DESTR_PLAIN_CYC,
    parameter int EXT_LONG_CYC_P = reset_seq_pkg::EXT_LONG_CYC,
    parameter int FUNC_LONG_CYC_P = reset_seq_pkg::FUNC_LONG_CYC,
    parameter int BOOT_FIRST_CYC_P = reset_seq_pkg::BOOT_FIRST_CYC,
    parameter int BOOT_LAST_CYC_P = reset_seq_pkg::BOOT_LAST_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Reset causes and settings
    input wire reset_seq_pkg::reset_cause_type cause_i,
    input wire logic selftest_en_i,
    input wire logic boot_hdr_last_i,
    // Two-way active-low reset line
    input wire logic reset_line_n_i,
    output logic reset_line_n_o,
    output logic reset_line_oe_o,
    // Status
    output reset_seq_pkg::seq_status_type status_o,
    output reset_seq_pkg::seq_kind_type seq_kind_o,
    output logic first_fetch_o,
    output logic [reset_seq_pkg::CNT_W-1:0] seq_duration_o,
    output logic [reset_seq_pkg::CNT_W-1:0] boot_duration_o
);
    import reset_seq_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    seq_state_type state_reg;
    seq_state_type state_next;
    seq_kind_type kind_reg;
    seq_kind_type kind_next;
    logic line_meta_reg;
    logic line_sync_reg;
    logic start_seq;
    logic timer_load;
    logic [CNT_W-1:0] timer_value;
    logic timer_expired;
    logic [CNT_W-1:0] seq_cnt_reg;
    logic [CNT_W-1:0] boot_cnt_reg;
    logic boot_started_reg;
    logic power_on_reg;

    // ----------------------------------------
    // Reset line synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            line_meta_reg <= 1'b0;
            line_sync_reg <= 1'b0;
        end else begin
            line_meta_reg <= reset_line_n_i;
            line_sync_reg <= line_meta_reg;
        end
    end

    // ----------------------------------------
    // Power-on request
    // ----------------------------------------
    // First cycle after reset starts a destructive sequence
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            power_on_reg <= 1'b1;
        end else begin
            power_on_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Sequence selection
    // ----------------------------------------
    always_comb begin
        start_seq = 1'b0;
        kind_next = kind_reg;
        if (power_on_reg) begin
            start_seq = 1'b1;
            kind_next = selftest_en_i ? KIND_DESTR_SELFTEST : KIND_DESTR_PLAIN; // see RL14
        end else if (state_reg == ST_RUN || state_reg == ST_BOOT) begin
            if (cause_i.destructive) begin
                start_seq = 1'b1;
                kind_next = selftest_en_i ? KIND_DESTR_SELFTEST : KIND_DESTR_PLAIN; // see RL14
            end else if (!line_sync_reg) begin
                start_seq = 1'b1;
                kind_next = KIND_EXT_LONG; // see RL8
            end else if (cause_i.functional_long) begin
                start_seq = 1'b1;
                kind_next = KIND_FUNC_LONG; // see RL14
            end else if (cause_i.functional_short) begin
                start_seq = 1'b1;
                kind_next = KIND_FUNC_SHORT; // see RL14
            end
        end
    end

    // ----------------------------------------
    // Phase timer load values
    // ----------------------------------------
    always_comb begin
        timer_load = 1'b0;
        timer_value = CNT_RST;
        if (start_seq) begin
            timer_load = 1'b1;
            case (kind_next)
                KIND_DESTR_SELFTEST: timer_value = CNT_W'(DESTR_SELFTEST_CYC_P); // see RL1
                KIND_DESTR_PLAIN: timer_value = CNT_W'(DESTR_PLAIN_CYC_P); // see RL2
                KIND_EXT_LONG: timer_value = CNT_W'(EXT_LONG_CYC_P); // see RL3
                KIND_FUNC_LONG: timer_value = CNT_W'(FUNC_LONG_CYC_P); // see RL4
                KIND_FUNC_SHORT: timer_value = CNT_W'(FUNC_SHORT_CYC); // see RL5
                default: timer_value = CNT_W'(DESTR_PLAIN_CYC_P);
            endcase
        end else if (state_reg == ST_STRETCH && line_sync_reg) begin
            timer_load = 1'b1;
            timer_value = boot_hdr_last_i ? CNT_W'(BOOT_LAST_CYC_P) : CNT_W'(BOOT_FIRST_CYC_P); // see RL11, RL12
        end
    end

    phase_timer u_phase_timer (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .load_value_i(timer_value),
        .expired_o(timer_expired)
    );

    // ----------------------------------------
    // Sequence state machine
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SEQ: begin
                if (timer_expired) begin
                    state_next = ST_STRETCH; // see RL10
                end
            end
            ST_STRETCH: begin
                if (line_sync_reg) begin
                    state_next = ST_BOOT; // see RL6
                end
            end
            ST_BOOT: begin
                if (start_seq) begin
                    state_next = ST_SEQ;
                end else if (boot_started_reg && timer_expired) begin
                    state_next = ST_RUN; // see RL7
                end
            end
            ST_RUN: begin
                if (start_seq) begin
                    state_next = ST_SEQ;
                end
            end
            default: state_next = ST_SEQ;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_SEQ;
            kind_reg <= KIND_DESTR_PLAIN;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
        end
    end

    // Guards against a stale expiry in the first boot cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            boot_started_reg <= 1'b0;
        end else begin
            boot_started_reg <= (state_reg == ST_BOOT);
        end
    end

    // ----------------------------------------
    // Reset line drive
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reset_line_n_o <= 1'b0;
            reset_line_oe_o <= 1'b1;
        end else begin
            reset_line_n_o <= 1'b0; // see RL9
            reset_line_oe_o <= (state_next == ST_SEQ); // see RL8, RL10
        end
    end

    // ----------------------------------------
    // Duration accounting
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            seq_cnt_reg <= CNT_RST;
            boot_cnt_reg <= CNT_RST;
        end else if (start_seq) begin
            seq_cnt_reg <= CNT_RST;
            boot_cnt_reg <= CNT_RST;
        end else if (state_reg == ST_SEQ || state_reg == ST_STRETCH) begin
            seq_cnt_reg <= seq_cnt_reg + 20'h00001; // see RL6
            boot_cnt_reg <= boot_cnt_reg + 20'h00001;
        end else if (state_reg == ST_BOOT) begin
            boot_cnt_reg <= boot_cnt_reg + 20'h00001; // see RL13
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_o <= '0;
            seq_kind_o <= KIND_DESTR_PLAIN;
            first_fetch_o <= 1'b0;
            seq_duration_o <= CNT_RST;
            boot_duration_o <= CNT_RST;
        end else begin
            status_o.in_reset <= (state_next == ST_SEQ || state_next == ST_STRETCH);
            status_o.boot_busy <= (state_next == ST_BOOT);
            status_o.default_run_mode <= (state_next == ST_RUN); // see RL7
            first_fetch_o <= (state_reg == ST_BOOT && state_next == ST_RUN); // see RL7
            seq_kind_o <= kind_next;
            seq_duration_o <= seq_cnt_reg;
            boot_duration_o <= boot_cnt_reg; // see RL13
        end
    end
endmodule

// ===== common/reset_seq_pkg.sv
// Constants and types for the reset sequence controller.
// What this block does
// RL1 - Destructive sequence with self test lasts at least 5.730 ms, typically 7.796 ms.
// RL2 - Destructive sequence without self test lasts at least 0.111 ms, typically 0.182 ms.
// RL3 - External long sequence lasts at least 5.729 ms, typically 7.793 ms.
// RL4 - Functional long sequence lasts at least 0.110 ms, typically 0.179 ms.
// RL5 - Functional short sequence lasts at least 0.007 ms, typically 0.009 ms.
// RL6 - Sequence stretches while the outside keeps the reset line low after the final phase.
// RL7 - At boot firmware end enter default run mode and fetch the first instruction.
// RL8 - Reset line is two-way; either side may pull it low.
// RL9 - Outside pull-up must overcome the weak pull-down; device never drives high.
// RL10 - Device releases its low drive at sequence end, giving the rising edge.
// RL11 - Boot firmware takes typically 200 us with header at first location.
// RL12 - Boot firmware takes typically 320 us with header at last location.
// RL13 - Total boot time is sequence duration plus boot firmware time.
// RL14 - Sequence chosen from reset cause and self-test setting, timed by cycle counters.
package reset_seq_pkg;

    // ----------------------------------------
    // Clock and counter width
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CNT_W = 20;

    // ----------------------------------------
    // Durations in nanoseconds, typical figures
    // ----------------------------------------
    localparam int DESTR_SELFTEST_TYP_NS = 7796000;
    localparam int DESTR_PLAIN_TYP_NS = 182000;
    localparam int EXT_LONG_TYP_NS = 7793000;
    localparam int FUNC_LONG_TYP_NS = 179000;
    localparam int FUNC_SHORT_TYP_NS = 9000;
    localparam int BOOT_FIRST_TYP_NS = 200000;
    localparam int BOOT_LAST_TYP_NS = 320000;

    // ----------------------------------------
    // Minimum durations in nanoseconds
    // ----------------------------------------
    localparam int DESTR_SELFTEST_MIN_NS = 5730000;
    localparam int DESTR_PLAIN_MIN_NS = 111000;
    localparam int EXT_LONG_MIN_NS = 5729000;
    localparam int FUNC_LONG_MIN_NS = 110000;
    localparam int FUNC_SHORT_MIN_NS = 7000;

    // ----------------------------------------
    // Cycle counts, rounded up
    // ----------------------------------------
    localparam int DESTR_SELFTEST_CYC = (DESTR_SELFTEST_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DESTR_PLAIN_CYC = (DESTR_PLAIN_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_LONG_CYC = (EXT_LONG_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FUNC_LONG_CYC = (FUNC_LONG_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FUNC_SHORT_CYC = (FUNC_SHORT_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_FIRST_CYC = (BOOT_FIRST_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_LAST_CYC = (BOOT_LAST_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FUNC_SHORT_MIN_CYC = (FUNC_SHORT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 20'h00000;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_SEQ = 4'h1,
        ST_STRETCH = 4'h2,
        ST_BOOT = 4'h4,
        ST_RUN = 4'h8
    } seq_state_type;

    typedef enum logic [2:0] {
        KIND_DESTR_SELFTEST = 3'h0,
        KIND_DESTR_PLAIN = 3'h1,
        KIND_EXT_LONG = 3'h2,
        KIND_FUNC_LONG = 3'h3,
        KIND_FUNC_SHORT = 3'h4
    } seq_kind_type;

    typedef struct packed {
        logic destructive;
        logic functional_long;
        logic functional_short;
    } reset_cause_type;

    typedef struct packed {
        logic default_run_mode;
        logic boot_busy;
        logic in_reset;
    } seq_status_type;

endpackage

// ===== rtl/phase_timer.sv
// Down counter that times one phase of the reset sequence.
`timescale 1ns/1ps
module phase_timer (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic load_i,
    input wire logic [reset_seq_pkg::CNT_W-1:0] load_value_i,
    // Status
    output logic expired_o
);
    import reset_seq_pkg::*;

    logic [CNT_W-1:0] count_reg;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            count_reg <= CNT_RST;
        end else if (load_i) begin
            count_reg <= load_value_i;
        end else if (count_reg != CNT_RST) begin
            count_reg <= count_reg - 20'h00001;
        end
    end

    // High in the last counted cycle
    assign expired_o = (count_reg == 20'h00001);
endmodule

// ===== bench/reset_line_partner.sv
// External reset generator with pull-up on the two-way reset line.
`timescale 1ns/1ps
module reset_line_partner (
    // Device side of the pin
    input wire logic dev_line_n_i,
    input wire logic dev_oe_i,
    // Generator control
    input wire logic gen_assert_i,
    // Resolved pin level
    output logic line_n_o
);
    // Pull-up wins unless a party pulls low
    assign line_n_o = !((dev_oe_i && !dev_line_n_i) || gen_assert_i);
endmodule

// ===== bench/reset_seq_assertions.sv
// Port checks for the reset sequence controller.
`timescale 1ns/1ps
module reset_seq_checker #(
    parameter int DESTR_SELFTEST_CYC_P = 1,
    parameter int DESTR_PLAIN_CYC_P = 1,
    parameter int EXT_LONG_CYC_P = 1,
    parameter int FUNC_LONG_CYC_P = 1,
    parameter int BOOT_FIRST_CYC_P = 1,
    parameter int BOOT_LAST_CYC_P = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Watched ports
    input wire reset_seq_pkg::reset_cause_type cause_i,
    input wire logic selftest_en_i,
    input wire logic boot_hdr_last_i,
    input wire logic reset_line_n_i,
    input wire logic reset_line_n_o,
    input wire logic reset_line_oe_o,
    input wire reset_seq_pkg::seq_status_type status_o,
    input wire reset_seq_pkg::seq_kind_type seq_kind_o,
    input wire logic first_fetch_o
);
    import reset_seq_pkg::*;
    int oe_cnt_reg;
    int boot_cnt_reg;
    int need_cyc;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge ref_clk_i) begin
        oe_cnt_reg <= (rst_i || !reset_line_oe_o) ? 0 : oe_cnt_reg + 1;
    end
    always_ff @(posedge ref_clk_i) begin
        boot_cnt_reg <= (rst_i || !status_o.boot_busy) ? 0 : boot_cnt_reg + 1;
    end
    always_comb begin
        case (seq_kind_o)
            KIND_DESTR_SELFTEST: need_cyc = DESTR_SELFTEST_CYC_P;
            KIND_DESTR_PLAIN: need_cyc = DESTR_PLAIN_CYC_P;
            KIND_EXT_LONG: need_cyc = EXT_LONG_CYC_P;
            KIND_FUNC_LONG: need_cyc = FUNC_LONG_CYC_P;
            default: need_cyc = FUNC_SHORT_CYC;
        endcase
    end
    // ------------------------------------
    // Sequences and assertions
    // ------------------------------------
    sequence line_held_low;
        !reset_line_n_i [*4];
    endsequence
    sequence dev_released;
        $fell(reset_line_oe_o) ##0 reset_line_n_i ##1 reset_line_n_i [*3];
    endsequence
    line_low_only_a: assert property (reset_line_oe_o |-> !reset_line_n_o)
        else $error("reset line driven high");
    seq_length_a: assert property ($fell(reset_line_oe_o) |-> oe_cnt_reg >= need_cyc)
        else $error("sequence too short");
    cause_taken_a: assert property (status_o.default_run_mode && cause_i != 3'h0 |=> reset_line_oe_o)
        else $error("cause not taken");
    kind_pick_a: assert property (status_o.default_run_mode && cause_i.destructive |=>
        seq_kind_o == ($past(selftest_en_i) ? KIND_DESTR_SELFTEST : KIND_DESTR_PLAIN)) else $error("wrong kind");
    stretch_hold_a: assert property (line_held_low ##0 !status_o.boot_busy &&
        !status_o.default_run_mode |=> !status_o.boot_busy) else $error("boot while line low");
    boot_start_a: assert property (dev_released |=> status_o.boot_busy)
        else $error("no boot after release");
    idle_pin_a: assert property (status_o.boot_busy || status_o.default_run_mode |-> !reset_line_oe_o)
        else $error("pin driven after sequence");
    fetch_pulse_a: assert property ($rose(status_o.default_run_mode) |-> first_fetch_o ##1 !first_fetch_o)
        else $error("bad first fetch pulse");
    boot_length_a: assert property ($rose(status_o.default_run_mode) |->
        boot_cnt_reg >= (boot_hdr_last_i ? BOOT_LAST_CYC_P : BOOT_FIRST_CYC_P)) else $error("boot too short");
endmodule
bind reset_sequence_controller reset_seq_checker #(
    .DESTR_SELFTEST_CYC_P(DESTR_SELFTEST_CYC_P), .DESTR_PLAIN_CYC_P(DESTR_PLAIN_CYC_P),
    .EXT_LONG_CYC_P(EXT_LONG_CYC_P), .FUNC_LONG_CYC_P(FUNC_LONG_CYC_P),
    .BOOT_FIRST_CYC_P(BOOT_FIRST_CYC_P), .BOOT_LAST_CYC_P(BOOT_LAST_CYC_P)
) chk_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cause_i(cause_i), .selftest_en_i(selftest_en_i),
    .boot_hdr_last_i(boot_hdr_last_i), .reset_line_n_i(reset_line_n_i), .reset_line_n_o(reset_line_n_o),
    .reset_line_oe_o(reset_line_oe_o), .status_o(status_o), .seq_kind_o(seq_kind_o),
    .first_fetch_o(first_fetch_o)
);

// ===== bench/test_reset_sequence_controller.sv
// Self-checking bench for the reset sequence controller.
`timescale 1ns/1ps
module test_reset_sequence_controller;
    import reset_seq_pkg::*;
    // ------------------------------------
    // Shortened counts and wiring
    // ------------------------------------
    localparam int ST_C = 100;
    localparam int PL_C = 60;
    localparam int EL_C = 90;
    localparam int FL_C = 50;
    localparam int BF_C = 40;
    localparam int BL_C = 70;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    reset_cause_type cause_i = 3'h0;
    logic selftest_en_i = 1'b0;
    logic boot_hdr_last_i = 1'b0;
    logic gen_assert = 1'b0;
    logic line_n;
    logic line_n_o;
    logic line_oe;
    seq_status_type status;
    seq_kind_type kind;
    logic first_fetch;
    logic [CNT_W-1:0] seq_dur;
    logic [CNT_W-1:0] boot_dur;
    int n_errors = 0;
    int num_checks = 0;
    always #10 ref_clk_i = !ref_clk_i;
    reset_sequence_controller #(.DESTR_SELFTEST_CYC_P(ST_C), .DESTR_PLAIN_CYC_P(PL_C), .EXT_LONG_CYC_P(EL_C),
        .FUNC_LONG_CYC_P(FL_C), .BOOT_FIRST_CYC_P(BF_C), .BOOT_LAST_CYC_P(BL_C)) dut_u (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cause_i(cause_i), .selftest_en_i(selftest_en_i),
        .boot_hdr_last_i(boot_hdr_last_i), .reset_line_n_i(line_n), .reset_line_n_o(line_n_o),
        .reset_line_oe_o(line_oe), .status_o(status), .seq_kind_o(kind), .first_fetch_o(first_fetch),
        .seq_duration_o(seq_dur), .boot_duration_o(boot_dur));
    reset_line_partner pu_u (.dev_line_n_i(line_n_o), .dev_oe_i(line_oe), .gen_assert_i(gen_assert),
        .line_n_o(line_n));
    // ------------------------------------
    // Shared tasks
    // ------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input int lo, input int hi, input logic [31:0] got);
        num_checks++;
        if (^got === 1'bx || got < lo || got > hi) begin
            n_errors++;
            $display("BAD %s exp %0d..%0d got %0d", what, lo, hi, got);
        end
    endtask
    function automatic logic probe(input int which);
        case (which)
            0: probe = line_oe;
            1: probe = !line_oe;
            2: probe = status.boot_busy;
            default: probe = status.default_run_mode;
        endcase
    endfunction
    task automatic wait_for(input int which, input int lim, output int cyc);
        cyc = 0;
        while (probe(which) !== 1'b1) begin
            @(negedge ref_clk_i);
            cyc++;
            if (cyc > lim) begin
                n_errors++;
                $display("BAD wait %0d exp done got timeout", which);
                give_verdict();
            end
        end
    endtask
    task automatic pulse(input reset_cause_type c);
        cause_i = c;
        @(negedge ref_clk_i);
        cause_i = 3'h0;
    endtask
    // One whole sequence: low drive, optional stretch, boot, run entry
    task automatic run_seq(input seq_kind_type k, input int n, input int b, input int hold);
        int c;
        wait_for(0, 5, c);
        check("kind", k, k, kind);
        check("in_reset", 1, 1, status.in_reset);
        gen_assert = (hold > 0);
        wait_for(1, n + 5, c);
        check("seq cycles", n, n + 1, c);
        repeat (hold) @(negedge ref_clk_i);
        check("early boot", 0, 0, status.boot_busy);
        gen_assert = 1'b0;
        wait_for(2, 8, c);
        wait_for(3, b + 5, c);
        check("boot cycles", b, b + 1, c);
        check("fetch", 1, 1, first_fetch);
        check("seq dur", n + hold, n + hold + 6, seq_dur);
        @(negedge ref_clk_i);
        check("fetch end", 0, 0, first_fetch);
        check("total dur", b, b + 1, boot_dur - seq_dur);
    endtask
    // ------------------------------------
    // Scenarios
    // ------------------------------------
    task automatic power_on();
        @(negedge ref_clk_i);
        run_seq(KIND_DESTR_PLAIN, PL_C, BF_C, 0);
    endtask
    task automatic destr_selftest();
        selftest_en_i = 1'b1;
        pulse(3'h4);
        selftest_en_i = 1'b0;
        run_seq(KIND_DESTR_SELFTEST, ST_C, BF_C, 0);
    endtask
    task automatic destr_last_header();
        boot_hdr_last_i = 1'b1;
        pulse(3'h5);
        run_seq(KIND_DESTR_PLAIN, PL_C, BL_C, 0);
        boot_hdr_last_i = 1'b0;
    endtask
    task automatic func_long();
        pulse(3'h3);
        run_seq(KIND_FUNC_LONG, FL_C, BF_C, 0);
    endtask
    task automatic func_short_stretch();
        pulse(3'h1);
        run_seq(KIND_FUNC_SHORT, FUNC_SHORT_CYC, BF_C, 30);
    endtask
    task automatic ext_long();
        gen_assert = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        gen_assert = 1'b0;
        run_seq(KIND_EXT_LONG, EL_C, BF_C, 0);
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_i);
        rst_i = 1'b0;
        power_on();
        destr_selftest();
        destr_last_header();
        func_long();
        func_short_stretch();
        ext_long();
        give_verdict();
    end
endmodule
